// File: rtl/i2c_master_rx.sv
// i2c master receive, acknowledge and stop sequencer with register port
//
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/1ps
module i2c_master_rx
	import i2c_rx_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	input  wire logic [1:0] addr,
	input  wire logic [7:0] wrData,
	input  wire logic       wrStb,
	input  wire logic       rdStb,
	output logic      [7:0] rdData,
	input  wire logic       sclIn,
	output logic            sclOut,
	output logic            sclOeN,
	input  wire logic       sdaIn,
	output logic            sdaOut,
	output logic            sdaOeN,
	output logic            serialIrq
);
	bus_line_if lines ();

	seq_e       state;
	logic [7:0] cnt;
	logic [2:0] bitCnt;
	logic [7:0] shiftReg;
	logic [7:0] dataBuf;
	logic [7:0] rate;
	logic       enable;
	logic       rcvEnable;
	logic       ackStart;
	logic       ackValue;
	logic       stopReq;
	logic       irqEnable;
	logic       bufFull;
	logic       eventFlag;
	logic       overrun;
	logic       writeCollision;
	logic       arbLoss;
	logic       startDet;
	logic       stopDet;
	logic       ctrlWr;
	logic       statWr;
	logic       dataWr;
	logic       dataRd;
	logic       idle;
	logic       goRx;
	logic       goAck;
	logic       goStop;
	logic       rxDone;
	logic       ackDone;
	logic       stopDone;
	logic       arbLossNow;
	logic [7:0] rxByte;

	function automatic logic rollover(input logic [7:0] c);
		return c == 8'h00;
	endfunction

	bus_line_monitor u_monitor (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.sclIn   (sclIn),
		.sdaIn   (sdaIn),
		.lines   (lines.monitor)
	);

	// register strobes and sequence launch
	assign ctrlWr = wrStb && addr == ADDR_CTRL;
	assign statWr = wrStb && addr == ADDR_STATUS;
	assign dataWr = wrStb && addr == ADDR_DATA;
	assign dataRd = rdStb && addr == ADDR_DATA;
	assign idle   = state == SEQ_IDLE;
	assign goStop = ctrlWr && enable && idle && wrData[CTRL_STOP];
	assign goAck  = ctrlWr && enable && idle && wrData[CTRL_ACK] && !wrData[CTRL_STOP];
	assign goRx   = ctrlWr && enable && idle && wrData[CTRL_RCV]
		&& !wrData[CTRL_ACK] && !wrData[CTRL_STOP];

	// completion and collision events
	assign rxByte   = {shiftReg[6:0], lines.sda};
	assign rxDone   = enable && state == SEQ_RX_HIGH && lines.scl && rollover(cnt) && bitCnt == BIT_LAST;
	assign ackDone  = state == SEQ_ACK_HIGH && lines.scl && rollover(cnt) && !arbLossNow;
	assign stopDone = enable && state == SEQ_STOP_DONE && rollover(cnt);
	assign arbLossNow = enable && (
		(state == SEQ_ACK_HIGH && sdaOeN && lines.scl && !lines.sda)
		|| (state == SEQ_STOP_HIGH && cnt != rate && !lines.scl)
		|| (state == SEQ_STOP_REL && rollover(cnt) && !lines.sda));

	// open drain: only ever pull low
	assign sclOut = 1'b0;
	assign sdaOut = 1'b0;

	// sequencer, rate counter and line drive
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state    <= SEQ_IDLE;
			cnt      <= 8'h00;
			bitCnt   <= 3'h0;
			shiftReg <= 8'h00;
			sclOeN   <= 1'b1;
			sdaOeN   <= 1'b1;
		end else if (!enable || arbLossNow) begin
			state  <= SEQ_IDLE;
			cnt    <= 8'h00;
			bitCnt <= 3'h0;
			sclOeN <= 1'b1;
			sdaOeN <= 1'b1;
		end else begin
			unique case (state)
				SEQ_IDLE: begin
					if (goStop) begin
						state  <= SEQ_STOP_SDA;
						sclOeN <= 1'b0;
						sdaOeN <= 1'b0;
					end else if (goAck) begin
						state  <= SEQ_ACK_LOW;
						cnt    <= rate;
						sclOeN <= 1'b0;
						sdaOeN <= wrData[CTRL_ACKVAL];
					end else if (goRx) begin
						state  <= SEQ_RX_LOW;
						cnt    <= rate;
						bitCnt <= 3'h0;
						sclOeN <= 1'b0;
						sdaOeN <= 1'b1;
					end
				end
				SEQ_RX_LOW: begin
					if (rollover(cnt)) begin
						state  <= SEQ_RX_HIGH;
						cnt    <= rate;
						sclOeN <= 1'b1;
					end else begin
						cnt <= cnt - 8'h01;
					end
				end
				SEQ_RX_HIGH: begin
					if (!lines.scl) begin
						cnt <= rate;
					end else if (rollover(cnt)) begin
						shiftReg <= rxByte;
						bitCnt   <= bitCnt + 3'h1;
						cnt      <= rate;
						sclOeN   <= 1'b0;
						state    <= (bitCnt == BIT_LAST) ? SEQ_IDLE : SEQ_RX_LOW;
					end else begin
						cnt <= cnt - 8'h01;
					end
				end
				SEQ_ACK_LOW: begin
					if (rollover(cnt)) begin
						state  <= SEQ_ACK_HIGH;
						cnt    <= rate;
						sclOeN <= 1'b1;
					end else begin
						cnt <= cnt - 8'h01;
					end
				end
				SEQ_ACK_HIGH: begin
					if (!lines.scl) begin
						cnt <= rate;
					end else if (rollover(cnt)) begin
						state  <= SEQ_IDLE;
						sclOeN <= 1'b0;
					end else begin
						cnt <= cnt - 8'h01;
					end
				end
				SEQ_STOP_SDA: begin
					if (!lines.sda) begin
						state <= SEQ_STOP_LOW;
						cnt   <= rate;
					end
				end
				SEQ_STOP_LOW: begin
					if (rollover(cnt)) begin
						state  <= SEQ_STOP_HIGH;
						cnt    <= rate;
						sclOeN <= 1'b1;
					end else begin
						cnt <= cnt - 8'h01;
					end
				end
				SEQ_STOP_HIGH: begin
					if (!lines.scl) begin
						cnt <= rate;
					end else if (rollover(cnt)) begin
						state  <= SEQ_STOP_REL;
						cnt    <= rate;
						sdaOeN <= 1'b1;
					end else begin
						cnt <= cnt - 8'h01;
					end
				end
				SEQ_STOP_REL: begin
					if (rollover(cnt)) begin
						state <= SEQ_STOP_DONE;
						cnt   <= rate;
					end else begin
						cnt <= cnt - 8'h01;
					end
				end
				SEQ_STOP_DONE: begin
					if (rollover(cnt)) begin
						state <= SEQ_IDLE;
					end else begin
						cnt <= cnt - 8'h01;
					end
				end
			endcase
		end
	end

	// control register, request bits cleared by hardware
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			enable    <= 1'b0;
			rcvEnable <= 1'b0;
			ackStart  <= 1'b0;
			ackValue  <= 1'b0;
			stopReq   <= 1'b0;
			irqEnable <= 1'b0;
			rate      <= RATE_RESET;
		end else begin
			if (ctrlWr) begin
				enable    <= wrData[CTRL_EN];
				ackValue  <= wrData[CTRL_ACKVAL];
				irqEnable <= wrData[CTRL_IRQEN];
			end
			if (wrStb && addr == ADDR_RATE) begin
				rate <= wrData;
			end
			if (!enable || arbLossNow) begin
				rcvEnable <= 1'b0;
				ackStart  <= 1'b0;
				stopReq   <= 1'b0;
			end else begin
				rcvEnable <= goRx | (rcvEnable & ~rxDone);
				ackStart  <= goAck | (ackStart & ~ackDone);
				stopReq   <= goStop | (stopReq & ~stopDone);
			end
		end
	end

	// data buffer
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			dataBuf <= 8'h00;
		end else if (rxDone) begin
			dataBuf <= rxByte;
		end else if (dataWr && idle) begin
			dataBuf <= wrData;
		end
	end

	// status flags, set wins over clear
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bufFull   <= 1'b0;
			eventFlag <= 1'b0;
			overrun   <= 1'b0;
			writeCollision <= 1'b0;
			arbLoss   <= 1'b0;
		end else begin
			bufFull   <= rxDone | (bufFull & ~dataRd);
			overrun   <= (rxDone & bufFull) | (overrun & ~(statWr & wrData[STAT_OVR]));
			writeCollision <= (dataWr & ~idle) | (writeCollision & ~(statWr & wrData[STAT_COLL]));
			arbLoss   <= arbLossNow | (arbLoss & ~(statWr & wrData[STAT_ARB]));
			eventFlag <= rxDone | ackDone | stopDone
				| (lines.stopSeen & startDet & ~stopReq & enable)
				| (eventFlag & ~(statWr & wrData[STAT_EVENT]));
		end
	end

	// bus start/stop status
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			startDet <= 1'b0;
			stopDet  <= 1'b0;
		end else if (!enable) begin
			startDet <= 1'b0;
			stopDet  <= 1'b0;
		end else if (lines.startSeen) begin
			startDet <= 1'b1;
			stopDet  <= 1'b0;
		end else if (lines.stopSeen) begin
			startDet <= 1'b0;
			stopDet  <= 1'b1;
		end
	end

	// read port, data valid one cycle after strobe
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdData <= 8'h00;
		end else if (rdStb) begin
			unique case (addr)
				ADDR_CTRL:   rdData <= {2'h0, irqEnable, stopReq, ackValue, ackStart, rcvEnable, enable};
				ADDR_STATUS: rdData <= {1'b0, stopDet, startDet, arbLoss, writeCollision, overrun, eventFlag, bufFull};
				ADDR_DATA:   rdData <= dataBuf;
				ADDR_RATE:   rdData <= rate;
			endcase
		end else begin
			rdData <= 8'h00;
		end
	end
	assign serialIrq = eventFlag & irqEnable;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	AST_RX_IGNORED: assert property (
		ctrlWr && wrData[CTRL_RCV] && !idle && !rcvEnable |=> !rcvEnable)
		else $error("receive accepted while busy");
	AST_RX_DONE: assert property (
		rxDone |=> bufFull && eventFlag && !rcvEnable && idle && !sclOeN && dataBuf == $past(rxByte))
		else $error("byte completion effects missing");
	AST_OVERRUN: assert property (
		rxDone && bufFull && !dataRd |=> overrun)
		else $error("overrun not flagged");
	AST_COLLISION: assert property (
		dataWr && !idle && !rxDone |=> writeCollision && $stable(dataBuf))
		else $error("collision write not refused");
	AST_ACK_DRIVE: assert property (
		goAck |=> !sclOeN && sdaOeN == $past(wrData[CTRL_ACKVAL]) && state == SEQ_ACK_LOW)
		else $error("ack start drive wrong");
	AST_ACK_END: assert property (
		ackDone |=> idle && !ackStart && !sclOeN)
		else $error("ack end wrong");
	AST_HOLD_LOW: assert property (
		idle && !sclOeN && enable && !arbLossNow |=> !sclOeN)
		else $error("scl released while waiting");
	AST_STOP_FIRST: assert property (
		goStop |=> !sdaOeN && !sclOeN && state == SEQ_STOP_SDA)
		else $error("stop did not pull sda");
	AST_STOP_EVENT: assert property (
		stopDone |=> !stopReq && eventFlag && idle)
		else $error("stop end wrong");
	AST_DISABLE: assert property (
		!enable |=> idle && sclOeN && sdaOeN && !startDet && !stopDet)
		else $error("disable did not clear");
	AST_ARB: assert property (
		arbLossNow |=> arbLoss && sclOeN && sdaOeN && idle && !stopReq && !ackStart)
		else $error("arbitration loss not handled");

	COV_RX: cover property (rxDone);
	COV_ACK: cover property (ackDone);
	COV_STOP: cover property (stopDone ##1 eventFlag);
	COV_ARB: cover property (arbLossNow);
endmodule

// File: rtl/i2c_rx_pkg.sv
// constants, states and register map of the i2c master receive sequencer
// How it works
// - receive request ignored unless sequencer idle
// - each rollover toggles scl, sda shifted in
// - eighth fall: buffer loaded, flags set, scl low
// - buffer full set on load, cleared by read
// - new byte while buffer full sets overrun
// - buffer write during receive flags collision
// - ack start pulls scl low, drives ack value
// - ack: period, release scl, period, pull low, idle
// - buffer write during ack flags collision
// - scl held low after byte until next command
// - stop: sda low, count, release scl, release sda
// - stop seen sets flag; event two periods after sda release
// - buffer write during stop flags collision
// - reset disables unit and aborts transfer
// - start and stop seen cleared on disable
// - foreign stop on busy bus raises interrupt
// - sda compared with intended level, mismatch flagged
// - counter reloads twice per scl period
// - collision aborts condition, releases lines, clears bit
package i2c_rx_pkg;
	localparam logic [1:0] ADDR_CTRL   = 2'h0;
	localparam logic [1:0] ADDR_STATUS = 2'h1;
	localparam logic [1:0] ADDR_DATA   = 2'h2;
	localparam logic [1:0] ADDR_RATE   = 2'h3;

	localparam int CTRL_EN     = 0;
	localparam int CTRL_RCV    = 1;
	localparam int CTRL_ACK    = 2;
	localparam int CTRL_ACKVAL = 3;
	localparam int CTRL_STOP   = 4;
	localparam int CTRL_IRQEN  = 5;

	localparam int STAT_FULL   = 0;
	localparam int STAT_EVENT  = 1;
	localparam int STAT_OVR    = 2;
	localparam int STAT_COLL   = 3;
	localparam int STAT_ARB    = 4;
	localparam int STAT_START  = 5;
	localparam int STAT_STOP   = 6;

	localparam logic [7:0] RATE_RESET = 8'h09;
	localparam logic [2:0] BIT_LAST   = 3'h7;

	typedef enum logic [3:0] {
		SEQ_IDLE,
		SEQ_RX_LOW,
		SEQ_RX_HIGH,
		SEQ_ACK_LOW,
		SEQ_ACK_HIGH,
		SEQ_STOP_SDA,
		SEQ_STOP_LOW,
		SEQ_STOP_HIGH,
		SEQ_STOP_REL,
		SEQ_STOP_DONE
	} seq_e;
endpackage

// File: rtl/bus_line_if.sv
// synchronised bus line levels and start/stop events
`timescale 1ns/1ps
interface bus_line_if;
	logic scl;
	logic sda;
	logic startSeen;
	logic stopSeen;
	modport monitor (output scl, output sda, output startSeen, output stopSeen);
	modport user    (input scl, input sda, input startSeen, input stopSeen);
endinterface

// File: rtl/bus_line_monitor.sv
// two-flop line synchronisers and start/stop condition detector
`timescale 1ns/1ps
module bus_line_monitor
	import i2c_rx_pkg::*;
(
	input  wire logic   sys_clk,
	input  wire logic   rst_n,
	input  wire logic   sclIn,
	input  wire logic   sdaIn,
	bus_line_if.monitor lines
);
	logic sclMeta;
	logic sclSync;
	logic sclPrev;
	logic sdaMeta;
	logic sdaSync;
	logic sdaPrev;

	// lines idle high after reset
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sclMeta <= 1'b1;
			sclSync <= 1'b1;
			sclPrev <= 1'b1;
			sdaMeta <= 1'b1;
			sdaSync <= 1'b1;
			sdaPrev <= 1'b1;
		end else begin
			sclMeta <= sclIn;
			sclSync <= sclMeta;
			sclPrev <= sclSync;
			sdaMeta <= sdaIn;
			sdaSync <= sdaMeta;
			sdaPrev <= sdaSync;
		end
	end

	assign lines.scl       = sclSync;
	assign lines.sda       = sdaSync;
	assign lines.startSeen = sclSync & sclPrev & sdaPrev & ~sdaSync;
	assign lines.stopSeen  = sclSync & sclPrev & ~sdaPrev & sdaSync;
endmodule

// File: testbench/i2c_slave_model.sv
// behavioural i2c slave that sends one byte msb first
`timescale 1ns/1ps
module i2c_slave_model (
	input  wire logic       scl,
	input  wire logic       load,
	input  wire logic [7:0] txByte,
	input  wire logic       slow,
	output logic            sdaLow,
	output logic            sclLow
);
	logic [7:0] sh;
	int         cnt;
	initial begin
		sdaLow = 0;
		sclLow = 0;
		cnt = 8;
	end
	always @(posedge load) begin
		sh = txByte;
		cnt = 0;
		sdaLow = ~sh[7];
	end
	// next bit after each falling scl, released after the eighth
	always @(negedge scl) begin
		if (cnt < 8) begin
			cnt = cnt + 1;
			sh = sh << 1;
			sdaLow = (cnt < 8) ? ~sh[7] : 1'b0;
			if (slow) begin
				sclLow = 1;
				#400 sclLow = 0;
			end
		end
	end
endmodule

// File: testbench/i2c_master_rx_bench.sv
// self-checking bench for the i2c master receive sequencer
`timescale 1ns/1ps
module i2c_master_rx_bench;
	import i2c_rx_pkg::*;
	logic       sys_clk = 0;
	logic       rst_n = 0;
	logic [1:0] addr = 0;
	logic [7:0] wrData = 0;
	logic       wrStb = 0;
	logic       rdStb = 0;
	logic [7:0] rdData;
	logic       sclOeN, sdaOeN, serialIrq, sdaLow, sclLow, sclDrv, sdaDrv;
	logic       load = 0, slow = 0, tbSda = 0;
	logic [7:0] txByte = 0, st, d, txb;
	wire        scl = (sclOeN | sclDrv) & ~sclLow;
	wire        sda = (sdaOeN | sdaDrv) & ~sdaLow & ~tbSda;
	int         failures = 0, tests_run = 0, seed = 1128, k;
	always #20 sys_clk = ~sys_clk;
	i2c_master_rx uut (.sys_clk(sys_clk), .rst_n(rst_n), .addr(addr), .wrData(wrData), .wrStb(wrStb),
		.rdStb(rdStb), .rdData(rdData), .sclIn(scl), .sclOut(sclDrv), .sclOeN(sclOeN), .sdaIn(sda),
		.sdaOut(sdaDrv), .sdaOeN(sdaOeN), .serialIrq(serialIrq));
	i2c_slave_model peer (.scl(scl), .load(load), .txByte(txByte), .slow(slow), .sdaLow(sdaLow),
		.sclLow(sclLow));
	task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("FAIL %s expected %h seen %h", n, exp, seen);
		end
	endtask
	// expected status word with the event bit set
	function automatic logic [7:0] flagsOf(input logic full, input logic ovr, input logic coll);
		flagsOf = 8'h00;
		flagsOf[STAT_FULL]  = full;
		flagsOf[STAT_EVENT] = 1'b1;
		flagsOf[STAT_OVR]   = ovr;
		flagsOf[STAT_COLL]  = coll;
	endfunction
	task automatic report_and_stop();
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		addr <= a;
		wrData <= v;
		wrStb <= 1;
		@(posedge sys_clk);
		wrStb <= 0;
	endtask
	task automatic rd(input logic [1:0] a, output logic [7:0] v);
		@(posedge sys_clk);
		addr <= a;
		rdStb <= 1;
		@(posedge sys_clk);
		rdStb <= 0;
		#1 v = rdData;
	endtask
	task automatic waitBit(input int b);
		int n;
		n = 0;
		st = 0;
		while (st[b] !== 1'b1 && n < 3000) begin
			rd(ADDR_STATUS, st);
			n++;
		end
		check("status wait", 8'(st[b]), 8'h01);
	endtask
	// receive with a collision write and a refused command
	task automatic rx(input logic [7:0] b);
		txByte <= b;
		wr(ADDR_CTRL, 8'h03);
		@(posedge sys_clk) load <= 1;
		wr(ADDR_DATA, ~b);
		load <= 0;
		wr(ADDR_CTRL, 8'h13);
		waitBit(STAT_EVENT);
	endtask
	initial begin
		#3000000;
		failures++;
		report_and_stop();
	end
	initial begin
		repeat (2) @(posedge sys_clk);
		rst_n <= 1;
		rd(ADDR_STATUS, d);
		check("status reset", d, 8'h00);
		rd(ADDR_RATE, d);
		check("rate reset", d, RATE_RESET);
		check("scl reset", 8'(sclOeN), 8'h01);
		wr(ADDR_CTRL, 8'h21);
		@(posedge sys_clk) tbSda <= 1;
		repeat (8) @(posedge sys_clk);
		rd(ADDR_STATUS, d);
		check("start seen", 8'(d[STAT_START]), 8'h01);
		@(posedge sys_clk) tbSda <= 0;
		repeat (10) @(posedge sys_clk);
		check("irq foreign stop", 8'(serialIrq), 8'h01);
		rd(ADDR_STATUS, d);
		check("stop seen", 8'(d[STAT_STOP]), 8'h01);
		wr(ADDR_CTRL, 8'h00);
		rd(ADDR_STATUS, d);
		check("seen cleared", d & 8'h60, 8'h00);
		wr(ADDR_STATUS, 8'h1E);
		d = 8'($random(seed));
		wr(ADDR_RATE, 8'h03 + (d & 8'h07));
		wr(ADDR_CTRL, 8'h01);
		for (k = 0; k < 2; k++) begin
			slow <= k[0];
			txb = (k == 0) ? 8'h01 : 8'($random(seed));
			rx(txb);
			check("rx flags", st & 8'h4F, flagsOf(1'b1, 1'b0, 1'b1));
			rd(ADDR_CTRL, d);
			check("rcv cleared", d & 8'h12, 8'h00);
			check("scl held", 8'(sclOeN), 8'h00);
			rd(ADDR_DATA, d);
			check("rx byte", d, txb);
			rd(ADDR_STATUS, d);
			check("full cleared", 8'(d[STAT_FULL]), 8'h00);
			wr(ADDR_STATUS, 8'h1E);
			wr(ADDR_CTRL, 8'h05 | 8'(k << 3));
			#1 check("ack level", 8'(sdaOeN), 8'(k));
			check("ack scl", 8'(sclOeN), 8'h00);
			wr(ADDR_DATA, 8'h00);
			wr(ADDR_CTRL, 8'h07 | 8'(k << 3));
			waitBit(STAT_EVENT);
			check("ack collision", st & 8'h08, 8'h08);
			rd(ADDR_CTRL, d);
			check("ack cleared", d & 8'h06, 8'h00);
			check("ack scl low", 8'(sclOeN), 8'h00);
			wr(ADDR_STATUS, 8'h1E);
		end
		wr(ADDR_CTRL, 8'h11);
		#1 check("stop sda", 8'(sdaOeN), 8'h00);
		wr(ADDR_DATA, 8'h00);
		waitBit(STAT_EVENT);
		check("stop flags", st & 8'h48, 8'h48);
		rd(ADDR_CTRL, d);
		check("stop cleared", d & 8'h10, 8'h00);
		check("stop lines", 8'({sclOeN, sdaOeN}), 8'h03);
		check("drive level", 8'({sclDrv, sdaDrv}), 8'h00);
		wr(ADDR_STATUS, 8'h1E);
		rx(8'($random(seed)));
		wr(ADDR_STATUS, 8'h0A);
		rx(8'($random(seed)));
		check("overrun", st & 8'h0F, flagsOf(1'b1, 1'b1, 1'b1));
		rd(ADDR_DATA, d);
		wr(ADDR_STATUS, 8'h1E);
		wr(ADDR_CTRL, 8'h0D);
		tbSda <= 1;
		waitBit(STAT_ARB);
		@(posedge sys_clk) tbSda <= 0;
		#1 check("arb lines", 8'({sclOeN, sdaOeN}), 8'h03);
		rd(ADDR_CTRL, d);
		check("arb ack cleared", d & 8'h04, 8'h00);
		wr(ADDR_STATUS, 8'h1E);
		wr(ADDR_CTRL, 8'h03);
		repeat (3) @(posedge sys_clk);
		rst_n <= 0;
		@(posedge sys_clk);
		rst_n <= 1;
		#1 check("reset abort", 8'({sclOeN, sdaOeN}), 8'h03);
		rd(ADDR_STATUS, d);
		check("reset status", d, 8'h00);
		report_and_stop();
	end
endmodule
